// ==== hw/fiss_device.sv ====
// Device end: input filters, frame builder and SPI slave shift register.
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module fiss_device #(
  parameter logic [15:0] PMASK1 = fiss_pkg::PARITY_MASK_1,
  parameter logic [15:0] PMASK2 = fiss_pkg::PARITY_MASK_2,
  parameter logic [15:0] PMASK3 = fiss_pkg::PARITY_MASK_3,
  parameter logic [15:0] PMASK4 = fiss_pkg::PARITY_MASK_4
) (
  input  wire logic       clk_i,                 // System clock.
  input  wire logic       rst_i,                 // Synchronous reset.
  input  wire logic       osc_tick_i,            // One pulse per oscillator period.
  input  wire logic [7:0] field_in_i,            // Comparator outputs, input 8 at bit 7.
  input  wire logic       frame_length_select_i, // High selects 16-bit frame.
  input  wire logic       filter_divider_select_i, // High selects ratio 64.
  input  wire logic       uv_below_on_i,         // Sensor supply below activation level.
  input  wire logic       uv_above_off_i,        // Sensor supply above release level.
  input  wire logic       ot_above_on_i,         // Junction above activation temperature.
  input  wire logic       ot_below_off_i,        // Junction below release temperature.
  input  wire logic       supply_low_i,          // Sensor supply below power-loss limit.
  input  wire logic       vdd_low_i,             // Internal supply below its limit.
  output logic      [7:0] mosi_data_o,           // Last word received from MOSI.
  fiss_if.device          spi                    // SPI link.
);
  // ==========================================================================
  // Filter clock and two-stage filter.
  // ==========================================================================
  logic [fiss_pkg::DIV_WIDTH-1:0] div_reg, div_next;
  logic                           fclk_tick;
  localparam int unsigned PAR_TOP = fiss_pkg::POS_PARITY_LO + fiss_pkg::NUM_PARITY - 1;
  logic [7:0] st1_reg, st1_next, st2_reg, st2_next, state_reg, state_next;
  logic       uv_n_reg, uv_n_next, ot_n_reg, ot_n_next, por_n_reg, por_n_next;

  always_comb begin
    div_next  = div_reg;
    fclk_tick = 1'b0;
    if (osc_tick_i) begin
      if ((filter_divider_select_i && div_reg == 6'(fiss_pkg::DIV_RATIO_HIGH - 1)) ||
          (!filter_divider_select_i && div_reg >= 6'(fiss_pkg::DIV_RATIO_LOW - 1))) begin
        div_next  = '0;
        fclk_tick = 1'b1;
      end else begin
        div_next = div_reg + 6'd1;
      end
    end
  end

  // Two filter stages must agree before the state register follows.
  always_comb begin
    st1_next   = st1_reg;
    st2_next   = st2_reg;
    state_next = state_reg;
    if (fclk_tick) begin
      st1_next = field_in_i;
      st2_next = st1_reg;
      for (int i = 0; i < fiss_pkg::NUM_INPUTS; i++) begin
        if (st1_reg[i] == st2_reg[i]) begin
          state_next[i] = st2_reg[i];
        end
      end
    end
  end

  // Hysteretic alarms, and power-loss reset.
  always_comb begin
    uv_n_next = uv_n_reg;
    ot_n_next = ot_n_reg;
    if (uv_below_on_i) begin
      uv_n_next = 1'b0;
    end else if (uv_above_off_i) begin
      uv_n_next = 1'b1;
    end
    if (ot_above_on_i) begin
      ot_n_next = 1'b0;
    end else if (ot_below_off_i) begin
      ot_n_next = 1'b1;
    end
    por_n_next = !(supply_low_i || vdd_low_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg   <= '0;
      st1_reg   <= '0;
      st2_reg   <= '0;
      state_reg <= '0;
      uv_n_reg  <= 1'b1;
      ot_n_reg  <= 1'b1;
      por_n_reg <= 1'b0;
    end else begin
      div_reg   <= div_next;
      st1_reg   <= st1_next;
      st2_reg   <= st2_next;
      state_reg <= state_next;
      uv_n_reg  <= uv_n_next;
      ot_n_reg  <= ot_n_next;
      por_n_reg <= por_n_next;
    end
  end

  // ==========================================================================
  // Frame build.
  // ==========================================================================
  logic [15:0] frame;
  logic [15:0] body;
  logic [15:0] pmask [fiss_pkg::NUM_PARITY];
  assign pmask[0] = PMASK1;
  assign pmask[1] = PMASK2;
  assign pmask[2] = PMASK3;
  assign pmask[3] = PMASK4;
  assign body = {state_reg, uv_n_reg, ot_n_reg, 6'h00};

  always_comb begin
    frame = body;
    frame[fiss_pkg::POS_STOP_LOW]  = 1'b0;
    frame[fiss_pkg::POS_STOP_HIGH] = 1'b1;
    for (int p = 0; p < fiss_pkg::NUM_PARITY; p++) begin
      frame[PAR_TOP - p] = ~^(body & pmask[p]);
    end
  end

  // ==========================================================================
  // SPI slave. Link pins are sampled as synchronous to clk_i.
  // ==========================================================================
  logic [15:0] shift_reg, shift_next;
  logic [7:0]  rx_reg, rx_next, mosi_data_reg, mosi_data_next;
  logic        cs_d_reg, sck_d_reg, mosi_bit_reg, mosi_bit_next;
  logic        long_reg, long_next;

  always_comb begin
    shift_next     = shift_reg;
    rx_next        = rx_reg;
    mosi_bit_next  = mosi_bit_reg;
    mosi_data_next = mosi_data_reg;
    long_next      = long_reg;
    if (!spi.cs_n && cs_d_reg) begin
      long_next  = frame_length_select_i;
      shift_next = frame_length_select_i ? frame : {state_reg, 8'h00};
    end else if (!spi.cs_n) begin
      if (spi.sck && !sck_d_reg) begin
        mosi_bit_next = spi.mosi;
      end else if (!spi.sck && sck_d_reg) begin
        shift_next = {shift_reg[14:0], 1'b0};
        rx_next    = {rx_reg[6:0], mosi_bit_reg};
      end
    end else if (!cs_d_reg) begin
      mosi_data_next = rx_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_reg     <= '0;
      rx_reg        <= '0;
      mosi_bit_reg  <= 1'b0;
      mosi_data_reg <= '0;
      long_reg      <= 1'b0;
      cs_d_reg      <= 1'b1;
      sck_d_reg     <= 1'b0;
    end else begin
      shift_reg     <= shift_next;
      rx_reg        <= rx_next;
      mosi_bit_reg  <= mosi_bit_next;
      mosi_data_reg <= mosi_data_next;
      long_reg      <= long_next;
      cs_d_reg      <= spi.cs_n;
      sck_d_reg     <= spi.sck;
    end
  end

  // The first bit is taken straight from the frame while the load is in flight.
  logic bit_out;
  always_comb begin
    if (cs_d_reg) begin
      bit_out = frame_length_select_i ? frame[15] : state_reg[7];
    end else begin
      bit_out = shift_reg[15];
    end
    if (!por_n_reg) begin
      bit_out = 1'b0;
    end
  end

  assign spi.miso_o    = bit_out;
  assign spi.miso_n_o  = ~bit_out;
  assign spi.miso_oe   = !spi.cs_n;
  assign spi.miso_n_oe = !spi.cs_n;
  assign mosi_data_o   = mosi_data_reg;
endmodule

// ==== hw/fiss_pkg.sv ====
// Shared constants for the filtered input SPI serializer.
package fiss_pkg;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int unsigned FRAME_LONG        = 16;
  localparam int unsigned FRAME_SHORT       = 8;
  localparam int unsigned NUM_INPUTS        = 8;
  localparam int unsigned NUM_PARITY        = 4;
  localparam int unsigned POS_UV_ALARM      = 7;
  localparam int unsigned POS_OT_ALARM      = 6;
  localparam int unsigned POS_PARITY_LO     = 2;
  localparam int unsigned POS_STOP_LOW      = 1;
  localparam int unsigned POS_STOP_HIGH     = 0;
  localparam int unsigned POS_INPUT_LO      = 8;

  // Default parity groupings: each mask selects a subset of frame bits 15..6 for one parity bit.
  localparam logic [15:0] PARITY_MASK_1     = 16'hF0C0;
  localparam logic [15:0] PARITY_MASK_2     = 16'hCC80;
  localparam logic [15:0] PARITY_MASK_3     = 16'hAA40;
  localparam logic [15:0] PARITY_MASK_4     = 16'h0FC0;

  // ==========================================================================
  // Filter clock
  // ==========================================================================
  localparam int unsigned DIV_RATIO_LOW     = 8;
  localparam int unsigned DIV_RATIO_HIGH    = 64;
  localparam int unsigned DIV_WIDTH         = 6;

  // ==========================================================================
  // Host SPI timing (200 MHz system clock)
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS     = 5000;
  localparam int unsigned SCK_HALF_NS       = 250;
  localparam int unsigned SCK_HALF_CYC      = (SCK_HALF_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned HALF_WIDTH        = 8;

  // ==========================================================================
  // Host control, status and data registers (Wishbone)
  // ==========================================================================
  localparam logic [3:0]  ADDR_CTRL         = 4'h0;
  localparam logic [3:0]  ADDR_STATUS       = 4'h4;
  localparam logic [3:0]  ADDR_DATA         = 4'h8;
  localparam int unsigned CTRL_START_BIT    = 0;
  localparam int unsigned CTRL_LONG_BIT     = 1;
  localparam int unsigned STAT_BUSY_BIT     = 0;
  localparam int unsigned STAT_POWER_BIT    = 1;
  localparam int unsigned STAT_PARITY_BIT   = 2;

  typedef enum logic [1:0] {
    FISS_IDLE  = 2'b00,
    FISS_LEAD  = 2'b01,
    FISS_HIGH  = 2'b10,
    FISS_LOW   = 2'b11
  } fiss_state_e;

endpackage

// ==== hw/fiss_if.sv ====
// SPI link between the serializer and its bus master.
`timescale 1ns/1ps
interface fiss_if;
  logic cs_n;        // Chip select, active low, driven by master.
  logic sck;         // Serial clock, idles low.
  logic mosi;        // Master data out.
  logic miso_o;      // Device data out value.
  logic miso_oe;     // Device drives data out.
  logic miso_n_o;    // Complementary data out value.
  logic miso_n_oe;   // Device drives complementary output.

  modport device (
    input  cs_n, sck, mosi,
    output miso_o, miso_oe, miso_n_o, miso_n_oe
  );
  modport master (
    output cs_n, sck, mosi,
    input  miso_o, miso_oe, miso_n_o, miso_n_oe
  );
endinterface

// ==== hw/fiss_master.sv ====
// Master end: Wishbone-controlled SPI mode-0 master reading the serializer.
`timescale 1ns/1ps
module fiss_master (
  input  wire logic        clk_i,   // System clock.
  input  wire logic        rst_i,   // Synchronous reset.
  input  wire logic        cyc_i,   // Wishbone cycle.
  input  wire logic        stb_i,   // Wishbone strobe.
  input  wire logic        we_i,    // Wishbone write enable.
  input  wire logic [3:0]  adr_i,   // Wishbone byte address.
  input  wire logic [3:0]  sel_i,   // Wishbone byte selects.
  input  wire logic [31:0] dat_i,   // Wishbone write data.
  output logic      [31:0] dat_o,   // Wishbone read data.
  output logic             ack_o,   // Wishbone acknowledge.
  fiss_if.master           spi      // SPI link.
);
  fiss_pkg::fiss_state_e st_reg, st_next;
  logic [7:0]  half_reg, half_next;
  logic [4:0]  bits_reg, bits_next;
  logic [15:0] rx_reg, rx_next, data_reg, data_next;
  logic [7:0]  tx_reg, tx_next;
  logic        long_reg, long_next, cs_reg, cs_next, sck_reg, sck_next;
  logic        pwr_reg, pwr_next, ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic        wr, rd;

  assign wr = cyc_i && stb_i && we_i && !ack_reg;
  assign rd = cyc_i && stb_i && !we_i && !ack_reg;

  always_comb begin
    st_next   = st_reg;
    half_next = half_reg;
    bits_next = bits_reg;
    rx_next   = rx_reg;
    tx_next   = tx_reg;
    data_next = data_reg;
    long_next = long_reg;
    cs_next   = cs_reg;
    sck_next  = sck_reg;
    pwr_next  = pwr_reg;
    ack_next  = cyc_i && stb_i && !ack_reg;
    dat_next  = dat_reg;
    if (rd) begin
      if (adr_i == fiss_pkg::ADDR_STATUS) begin
        dat_next = {29'h0000_0000, ^data_reg == long_reg, pwr_reg, st_reg != fiss_pkg::FISS_IDLE};
      end else if (adr_i == fiss_pkg::ADDR_DATA) begin
        dat_next = {16'h0000, data_reg};
      end else begin
        dat_next = 32'h0000_0000;
      end
    end
    case (st_reg)
      fiss_pkg::FISS_IDLE: begin
        if (wr && adr_i == fiss_pkg::ADDR_CTRL && sel_i[0] && dat_i[fiss_pkg::CTRL_START_BIT]) begin
          long_next = dat_i[fiss_pkg::CTRL_LONG_BIT];
          tx_next   = dat_i[15:8];
          cs_next   = 1'b0;
          half_next = '0;
          bits_next = '0;
          rx_next   = '0;
          st_next   = fiss_pkg::FISS_LEAD;
        end
      end
      fiss_pkg::FISS_LEAD, fiss_pkg::FISS_LOW: begin
        half_next = half_reg + 8'd1;
        if (half_reg == 8'(fiss_pkg::SCK_HALF_CYC - 1)) begin
          half_next = '0;
          if (bits_reg == (long_reg ? 5'(fiss_pkg::FRAME_LONG) : 5'(fiss_pkg::FRAME_SHORT))) begin
            cs_next   = 1'b1;
            data_next = rx_reg;
            pwr_next  = !long_reg || rx_reg[0];
            st_next   = fiss_pkg::FISS_IDLE;
          end else begin
            sck_next  = 1'b1;
            rx_next   = {rx_reg[14:0], spi.miso_o};
            bits_next = bits_reg + 5'd1;
            st_next   = fiss_pkg::FISS_HIGH;
          end
        end
      end
      fiss_pkg::FISS_HIGH: begin
        half_next = half_reg + 8'd1;
        if (half_reg == 8'(fiss_pkg::SCK_HALF_CYC - 1)) begin
          half_next = '0;
          sck_next  = 1'b0;
          tx_next   = {tx_reg[6:0], 1'b0};
          st_next   = fiss_pkg::FISS_LOW;
        end
      end
      default: st_next = fiss_pkg::FISS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg   <= fiss_pkg::FISS_IDLE;
      half_reg <= '0;
      bits_reg <= '0;
      rx_reg   <= '0;
      tx_reg   <= '0;
      data_reg <= '0;
      long_reg <= 1'b1;
      cs_reg   <= 1'b1;
      sck_reg  <= 1'b0;
      pwr_reg  <= 1'b0;
      ack_reg  <= 1'b0;
      dat_reg  <= '0;
    end else begin
      st_reg   <= st_next;
      half_reg <= half_next;
      bits_reg <= bits_next;
      rx_reg   <= rx_next;
      tx_reg   <= tx_next;
      data_reg <= data_next;
      long_reg <= long_next;
      cs_reg   <= cs_next;
      sck_reg  <= sck_next;
      pwr_reg  <= pwr_next;
      ack_reg  <= ack_next;
      dat_reg  <= dat_next;
    end
  end

  assign spi.cs_n = cs_reg;
  assign spi.sck  = sck_reg;
  assign spi.mosi = tx_reg[7];
  assign dat_o    = dat_reg;
  assign ack_o    = ack_reg;
endmodule

// ==== testbench/fiss_link_properties.sv ====
// Concurrent checks on the SPI link between the two serializer ends.
`timescale 1ns/1ps
module fiss_link_check (
  input wire logic clk_i,      // Clock.
  input wire logic rst_i,      // Reset.
  input wire logic cs_n_i,     // Select, active low.
  input wire logic sck_i,      // Serial clock.
  input wire logic mosi_i,     // Master data.
  input wire logic miso_i,     // Device data.
  input wire logic miso_oe_i,  // Data enable.
  input wire logic miso_n_i,   // Inverse data.
  input wire logic miso_n_oe_i // Inverse enable.
);
  // ==========================================================================
  // Clock rise counter
  // ==========================================================================
  logic [4:0] bits_reg;
  logic [4:0] bits_next;
  logic       sck_reg;
  logic       sck_next;

  always_comb begin
    bits_next = cs_n_i ? 5'h00 : bits_reg + {4'h0, sck_i & ~sck_reg};
    sck_next  = sck_i;
  end

  always_ff @(posedge clk_i) begin
    bits_reg <= rst_i ? 5'h00 : bits_next;
    sck_reg  <= rst_i ? 1'b0 : sck_next;
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_lead;
    !sck_i [*8];
  endsequence
  sequence s_first_hold;
    ##2 $stable(miso_i) [*6];
  endsequence

  a_idle_tristate: assert property (cs_n_i |-> !miso_oe_i && !miso_n_oe_i)
    else $error("outputs driven while deselected");
  a_select_drive: assert property (!cs_n_i |-> miso_oe_i && miso_n_oe_i)
    else $error("outputs idle while selected");
  a_comp_inverse: assert property (!cs_n_i |-> miso_n_i == !miso_i)
    else $error("inverse output wrong");
  a_miso_high_hold: assert property (!cs_n_i && sck_i && $past(sck_i) |-> $stable(miso_i))
    else $error("data changed while clock high");
  a_sck_idle_low: assert property (cs_n_i |-> !sck_i)
    else $error("clock active while deselected");
  a_lead_time: assert property ($fell(cs_n_i) |-> s_lead)
    else $error("clock rose too soon after select");
  a_first_bit: assert property ($fell(cs_n_i) |-> s_first_hold)
    else $error("first bit not held");
  a_frame_bits: assert property ($rose(cs_n_i) |-> bits_reg == 5'h08 || bits_reg == 5'h10)
    else $error("frame length not 8 or 16");
  a_mosi_hold: assert property (sck_i && $past(sck_i) |-> $stable(mosi_i))
    else $error("master data changed while clock high");
endmodule

// ==== testbench/tb_top.sv ====
// Bench: Wishbone-driven master reads frames from the device end.
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, osc_tick = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000, dat_r, q;
  logic [1:0]  tick_cnt = 2'h0;
  logic [7:0]  field = 8'hA5, mosi_data;
  logic        flen = 1'b1, fdiv = 1'b0, sup_low = 1'b0, vdd_low = 1'b0;
  logic        uv_on = 1'b0, uv_off = 1'b1, ot_on = 1'b0, ot_off = 1'b1;
  int          fail_count = 0;
  int          comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    tick_cnt <= tick_cnt + 2'h1;
    osc_tick <= (tick_cnt == 2'h3);
  end

  fiss_if u_fiss_if ();
  fiss_device u_fiss_device (
    .clk_i(clk_i), .rst_i(rst_i), .osc_tick_i(osc_tick), .field_in_i(field),
    .frame_length_select_i(flen), .filter_divider_select_i(fdiv),
    .uv_below_on_i(uv_on), .uv_above_off_i(uv_off), .ot_above_on_i(ot_on),
    .ot_below_off_i(ot_off), .supply_low_i(sup_low), .vdd_low_i(vdd_low),
    .mosi_data_o(mosi_data), .spi(u_fiss_if)
  );
  fiss_master u_fiss_master (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .spi(u_fiss_if)
  );
  fiss_link_check u_fiss_link_check (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(u_fiss_if.cs_n), .sck_i(u_fiss_if.sck),
    .mosi_i(u_fiss_if.mosi), .miso_i(u_fiss_if.miso_o), .miso_oe_i(u_fiss_if.miso_oe),
    .miso_n_i(u_fiss_if.miso_n_o), .miso_n_oe_i(u_fiss_if.miso_n_oe)
  );

  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk_i);
  endtask

  // Starts one transfer and waits until the status shows it has finished.
  task automatic frame(input logic lng, input logic [7:0] b, output logic [31:0] f);
    logic [31:0] s;
    wb(1'b1, fiss_pkg::ADDR_CTRL, {16'h0000, b, 6'h00, lng, 1'b1}, s);
    do begin
      wb(1'b0, fiss_pkg::ADDR_STATUS, 32'h0000_0000, s);
    end while (s[fiss_pkg::STAT_BUSY_BIT] !== 1'b0);
    wb(1'b0, fiss_pkg::ADDR_DATA, 32'h0000_0000, f);
  endtask

  function automatic logic [31:0] exp_frame(input logic [7:0] d, input logic uv, input logic ot);
    logic [15:0] f;
    f = {d, uv, ot, 4'h0, 2'b01};
    f[5] = ~^(f & fiss_pkg::PARITY_MASK_1);
    f[4] = ~^(f & fiss_pkg::PARITY_MASK_2);
    f[3] = ~^(f & fiss_pkg::PARITY_MASK_3);
    f[2] = ~^(f & fiss_pkg::PARITY_MASK_4);
    return {16'h0000, f};
  endfunction

  task automatic expect_frame(input logic [7:0] d, input logic uv, input logic ot);
    frame(1'b1, 8'h3C, q);
    check(q, exp_frame(d, uv, ot), "16-bit frame content");
  endtask

  initial begin
    settle(16);
    rst_i <= 1'b0;
    settle(1);
    settle(200);
    expect_frame(8'hA5, 1'b1, 1'b1);
    check({24'h00_0000, mosi_data}, 32'h0000_0000, "received master byte");
    wb(1'b0, fiss_pkg::ADDR_STATUS, 32'h0000_0000, q);
    check({31'h0, q[fiss_pkg::STAT_POWER_BIT]}, 32'h0000_0001, "stop bit high");
    wb(1'b0, 4'hC, 32'h0000_0000, q);
    check(q, 32'h0000_0000, "unmapped read");
    // Alarm set, hold between thresholds, then release.
    for (int i = 0; i < 3; i++) begin
      uv_on <= (i == 0);
      ot_on <= (i == 0);
      uv_off <= (i == 2);
      ot_off <= (i == 2);
      settle(200);
      expect_frame(8'hA5, i == 2, i == 2);
    end
    for (int i = 0; i < 2; i++) begin
      sup_low <= (i == 0);
      vdd_low <= (i == 1);
      settle(200);
      frame(1'b1, 8'h3C, q);
      check(q, 32'h0000_0000, "power loss forces low data");
      wb(1'b0, fiss_pkg::ADDR_STATUS, 32'h0000_0000, q);
      check({31'h0, q[fiss_pkg::STAT_POWER_BIT]}, 32'h0000_0000, "stop bit low");
    end
    sup_low <= 1'b0;
    vdd_low <= 1'b0;
    flen <= 1'b0;
    settle(200);
    frame(1'b0, 8'hC3, q);
    check({24'h00_0000, q[7:0]}, 32'h0000_00A5, "8-bit frame");
    check({24'h00_0000, mosi_data}, 32'h0000_00C3, "received byte short");
    flen <= 1'b1;
    field <= 8'h0F;
    settle(100);
    expect_frame(8'h0F, 1'b1, 1'b1);
    check({24'h00_0000, mosi_data}, 32'h0000_0000, "received byte long");
    field <= 8'hF0;
    settle(40);
    expect_frame(8'h0F, 1'b1, 1'b1);
    fdiv <= 1'b1;
    settle(100);
    field <= 8'h33;
    settle(300);
    expect_frame(8'hF0, 1'b1, 1'b1);
    expect_frame(8'h33, 1'b1, 1'b1);
    print_verdict();
  end

  initial begin
    settle(80000);
    fail_count++;
    print_verdict();
  end
endmodule
